// [hw/mcs_align_rx.sv]
// Multichip alignment receive logic: alignment input sampling with a
// programmable delay, edge and code modes, 32-state clock sequencer,
// NCO phase accumulator initialisation and alignment margin check.
// Assumes sys_clk is the conversion sample clock; all pins asynchronous.
//
// Overview of operation
// - Init pulse one sample cycle, forces sequencer
// - Edge mode: pulse per rising alignment edge
// - Code mode: pulse per recognised code
// - Init pulse loads sequencer load value
// - Sequencer cycles 32 states, reload keeps phase
// - Load value increment advances clocks one cycle
// - Edge mode: common transmit strobe resets NCO accumulator
// - Code mode slave takes master NCO phase
// - Alignment input sampled by sample clock
// - Strobe sampled by data clock, polarity selectable
// - Margin below threshold sets fault flag
// - Check select zero means manual mode
// - Five-bit delay tap on alignment input
// - Interrupt enable gates fault onto request
// - Writing one clears the fault flag
// - Fault type tells setup from hold
// - Fault flag latches until a write of one clears it
// - Masked flag cannot drive interrupt request
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_align_rx (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire mcs_pkg::mcs_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // Pins from the far side
  input wire logic align_rx_pin,
  input wire logic transmit_strobe_pin,
  input wire logic input_data_clock,
  // NCO tuning from the datapath
  input wire logic [31:0] nco_ftw,
  // Sequencer and NCO state
  output logic init_pulse,
  output logic [4:0] seq_state,
  output logic [31:0] nco_phase,
  // Open-drain interrupt request, active low
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  import mcs_pkg::*;

  //////////////////////////////////////////////////////////////////////
  logic [31:0] chip_mode_ff;
  logic [31:0] align_ctrl_ff;
  logic irq_en_ff;
  logic fault_ff;
  logic fault_type_ff;
  logic [31:0] rdata_ff;

  logic rx_s;
  logic dclk_s;
  logic stb_s;
  logic dclk_d_ff;
  logic stb_prev_ff;
  logic [`MCS_DLY_TAPS-1:0] dly_ff;
  logic smp_prev_ff;
  logic smp;
  logic [4:0] tap;
  logic [3:0] margin;
  logic edge_mode;
  logic code_mode;
  logic edge_hit;
  logic code_hit;
  logic nxt_init;
  logic setup_bad;
  logic hold_bad;
  logic margin_fault;
  logic dclk_rise;
  logic strobe_evt;
  logic fault_clr;

  mcs_pn_st_t pn_st_ff;
  logic [3:0] pn_cnt_ff;
  logic [`MCS_PHASE_BITS-1:0] pn_phase_ff;
  logic irq_n_seen_unused;

  assign irq_n_seen_unused = irq_n_in;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  mcs_sync2 u_sync_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(align_rx_pin),
    .sync_out(rx_s)
  );

  mcs_sync2 u_sync_dclk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(input_data_clock),
    .sync_out(dclk_s)
  );

  mcs_sync2 u_sync_stb (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(transmit_strobe_pin),
    .sync_out(stb_s)
  );

  //////////////////////////////////////////////////////////////////////
  // Register port

  assign fault_clr = bus_req.wr && (bus_req.addr == `MCS_ADDR_FAULT) &&
                     bus_req.wdata[`MCS_FS_FLAG];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chip_mode_ff <= `MCS_RST_CHIP_MODE;
      align_ctrl_ff <= `MCS_RST_ALIGN_CTRL;
      irq_en_ff <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `MCS_ADDR_CHIP_MODE) begin
        chip_mode_ff <= bus_req.wdata;
      end else if (bus_req.addr == `MCS_ADDR_ALIGN_CTRL) begin
        align_ctrl_ff <= bus_req.wdata;
      end else if (bus_req.addr == `MCS_ADDR_FAULT) begin
        irq_en_ff <= bus_req.wdata[`MCS_FS_IRQ_EN];
      end
    end
  end

  // Read data stand one cycle after the strobe and only then
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (bus_req.rd) begin
      if (bus_req.addr == `MCS_ADDR_CHIP_MODE) begin
        rdata_ff <= chip_mode_ff;
      end else if (bus_req.addr == `MCS_ADDR_ALIGN_CTRL) begin
        rdata_ff <= align_ctrl_ff;
      end else if (bus_req.addr == `MCS_ADDR_FAULT) begin
        rdata_ff <= 32'h00000000;
        rdata_ff[`MCS_FS_IRQ_EN] <= irq_en_ff;
        rdata_ff[`MCS_FS_TYPE] <= fault_type_ff;
        rdata_ff[`MCS_FS_FLAG] <= fault_ff;
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign bus_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////
  // Mode decode

  assign edge_mode = align_ctrl_ff[`MCS_AC_RX_EN] &&
                     chip_mode_ff[`MCS_CM_PULSE_EN] &&
                     !chip_mode_ff[`MCS_CM_CODE_EN];
  assign code_mode = align_ctrl_ff[`MCS_AC_RX_EN] &&
                     chip_mode_ff[`MCS_CM_CODE_EN] &&
                     !chip_mode_ff[`MCS_CM_PULSE_EN];

  assign tap = align_ctrl_ff[`MCS_AC_TAP_HI:`MCS_AC_TAP_LO];
  assign margin = align_ctrl_ff[`MCS_AC_MARGIN_HI:`MCS_AC_MARGIN_LO];

  //////////////////////////////////////////////////////////////////////
  // Delay line on the alignment input

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= {dly_ff[`MCS_DLY_TAPS-2:0], rx_s};
    end
  end

  assign smp = dly_ff[tap];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      smp_prev_ff <= 1'b0;
    end else begin
      smp_prev_ff <= smp;
    end
  end

  assign edge_hit = edge_mode && smp && !smp_prev_ff;

  //////////////////////////////////////////////////////////////////////
  // Code mode recognition

  mcs_pn_corr u_corr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bit_in(smp),
    .enable(code_mode),
    .threshold(align_ctrl_ff[`MCS_AC_CORR_HI:`MCS_AC_CORR_LO]),
    .hit(code_hit)
  );

  //////////////////////////////////////////////////////////////////////
  // Init pulse and sequencer

  assign nxt_init = edge_hit || code_hit;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      init_pulse <= 1'b0;
    end else begin
      init_pulse <= nxt_init;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seq_state <= 5'h00;
    end else if (init_pulse) begin
      seq_state <= {1'b0, align_ctrl_ff[`MCS_AC_CLKST_HI:`MCS_AC_CLKST_LO]};
    end else begin
      seq_state <= seq_state + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit strobe, sampled on data clock rising edges

  assign dclk_rise = dclk_s && !dclk_d_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dclk_d_ff <= 1'b0;
    end else begin
      dclk_d_ff <= dclk_s;
    end
  end

  // Idle level follows polarity so the first sample is no false event
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_prev_ff <= 1'b1;
    end else if (dclk_rise) begin
      stb_prev_ff <= stb_s ^ chip_mode_ff[`MCS_CM_STB_INV];
    end
  end

  assign strobe_evt = dclk_rise && stb_prev_ff &&
                      !(stb_s ^ chip_mode_ff[`MCS_CM_STB_INV]);

  //////////////////////////////////////////////////////////////////////
  // Master phase recovery in code mode

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pn_st_ff <= MCS_PN_HUNT;
      pn_cnt_ff <= 4'h0;
      pn_phase_ff <= '0;
    end else begin
      case (pn_st_ff)
        MCS_PN_HUNT: begin
          pn_cnt_ff <= 4'h0;
          // First phase chip stands beside the hit, so take it here
          if (code_hit) begin
            pn_st_ff <= MCS_PN_PHASE;
            pn_cnt_ff <= 4'h1;
            pn_phase_ff <= {{(`MCS_PHASE_BITS-1){1'b0}}, smp};
          end
        end
        MCS_PN_PHASE: begin
          pn_phase_ff <= {pn_phase_ff[`MCS_PHASE_BITS-2:0], smp};
          pn_cnt_ff <= pn_cnt_ff + 4'h1;
          if (!code_mode || pn_cnt_ff == 4'hF) begin
            pn_st_ff <= MCS_PN_HUNT;
          end
        end
        default: begin
          pn_st_ff <= MCS_PN_HUNT;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // NCO phase accumulator

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nco_phase <= 32'h00000000;
    end else if (edge_mode && strobe_evt) begin
      nco_phase <= 32'h00000000;
    end else if (pn_st_ff == MCS_PN_PHASE && pn_cnt_ff == 4'hF && code_mode) begin
      nco_phase <= {pn_phase_ff[`MCS_PHASE_BITS-2:0], smp, 16'h0000};
    end else begin
      nco_phase <= nco_phase + nco_ftw;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Margin check around each detected edge

  always_comb begin
    setup_bad = 1'b0;
    hold_bad = 1'b0;
    for (int k = 1; k <= 16; k++) begin
      if (k <= int'(margin) + 1) begin
        if (int'(tap) + k < `MCS_DLY_TAPS) begin
          if (dly_ff[int'(tap) + k] != smp_prev_ff) begin
            setup_bad = 1'b1;
          end
        end
        if (int'(tap) - k >= 0) begin
          if (dly_ff[int'(tap) - k] != smp) begin
            hold_bad = 1'b1;
          end
        end
      end
    end
  end

  assign margin_fault = (edge_hit || (code_mode && smp != smp_prev_ff)) &&
                        !align_ctrl_ff[`MCS_AC_CHK_MODE] &&
                        (setup_bad || hold_bad);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
    end else if (margin_fault) begin
      fault_ff <= 1'b1;
    end else if (fault_clr) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_type_ff <= 1'b0;
    end else if (margin_fault) begin
      fault_type_ff <= hold_bad && !setup_bad;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt request pin

  assign irq_n_out = 1'b0;

  assign irq_n_oe_n = !(fault_ff && irq_en_ff);

endmodule

// [hw/mcs_pkg.sv]
// Types shared by the multichip alignment receive block.
// Assumes the constant header sits in the include path.
`include "mcs_regs.svh"

package mcs_pkg;

  // Register port request, all fields same clock as sys_clk
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mcs_bus_req_t;

  // Code mode phase recovery state
  typedef enum logic [0:0] {
    MCS_PN_HUNT = 1'b0,
    MCS_PN_PHASE = 1'b1
  } mcs_pn_st_t;

endpackage

// [hw/mcs_pn_corr.sv]
// Code correlator: flags when the received chip stream matches the
// expected code in at least the threshold number of positions.
// Assumes one chip per sys_clk cycle on an already synchronised bit.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_pn_corr (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Stream and control
  input wire logic bit_in,
  input wire logic enable,
  input wire logic [4:0] threshold,
  // One-cycle recognition pulse
  output logic hit
);

  // Literal copy so single chips can be selected
  localparam logic [`MCS_CODE_LEN-1:0] code_word = `MCS_CODE_WORD;

  logic [`MCS_CODE_LEN-1:0] chips_ff;
  logic [`MCS_CODE_LEN-1:0] nxt_chips;
  logic match_ff;
  logic [4:0] agree;
  logic match_now;

  always_comb begin
    nxt_chips = {chips_ff[`MCS_CODE_LEN-2:0], bit_in};
    agree = 5'h00;
    for (int i = 0; i < `MCS_CODE_LEN; i++) begin
      agree = agree + {4'h0, ~(nxt_chips[i] ^ code_word[i])};
    end
    match_now = enable && (agree >= threshold);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chips_ff <= '0;
      match_ff <= 1'b0;
      hit <= 1'b0;
    end else begin
      chips_ff <= nxt_chips;
      match_ff <= match_now;
      // One pulse per recognition, not per matching cycle
      hit <= match_now && !match_ff;
    end
  end

endmodule

// [hw/mcs_regs.svh]
// Register offsets, field positions, reset values and counts of the
// multichip alignment receive block. Included by the package and the top.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// Register offsets on the plain register port
`define MCS_ADDR_CHIP_MODE 8'h01
`define MCS_ADDR_ALIGN_CTRL 8'h03
`define MCS_ADDR_FAULT 8'h09

// chip_mode_control fields
`define MCS_CM_CODE_EN 13
`define MCS_CM_SYNC_SEL 12
`define MCS_CM_PULSE_EN 11
`define MCS_CM_STB_INV 1

// alignment_control fields
`define MCS_AC_CORR_HI 31
`define MCS_AC_CORR_LO 27
`define MCS_AC_RX_EN 26
`define MCS_AC_TX_EN 25
`define MCS_AC_TAP_HI 23
`define MCS_AC_TAP_LO 19
`define MCS_AC_CHK_MODE 18
`define MCS_AC_SET_HIGH 10
`define MCS_AC_CLKST_HI 7
`define MCS_AC_CLKST_LO 4
`define MCS_AC_MARGIN_HI 3
`define MCS_AC_MARGIN_LO 0

// fault_status_and_enable fields
`define MCS_FS_IRQ_EN 0
`define MCS_FS_TYPE 4
`define MCS_FS_FLAG 6

// Reset values
`define MCS_RST_CHIP_MODE 32'h00000000
`define MCS_RST_ALIGN_CTRL 32'h80000000

// Sequencer, delay line and code figures
`define MCS_SEQ_STATES 32
`define MCS_DLY_TAPS 32
`define MCS_CODE_LEN 16
`define MCS_CODE_WORD 16'hB36A
`define MCS_PHASE_BITS 16

`endif

// [hw/mcs_sync2.sv]
// Two flip-flop level synchroniser for one pin.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps

module mcs_sync2 (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pin and synchronised level
  input wire logic async_in,
  output logic sync_out
);

  logic stage1_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1_ff <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1_ff <= async_in;
      sync_out <= stage1_ff;
    end
  end

endmodule

// [sim/mcs_align_rx_sva.sv]
// Checker for the alignment receive block, watching its ports only.
// Assumes control bits change only through the register port.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_align_rx_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire mcs_pkg::mcs_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  // Alignment and sequencer
  input wire logic align_rx_pin,
  input wire logic init_pulse,
  input wire logic [4:0] seq_state,
  // Interrupt pin
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n
);
  import mcs_pkg::*;
  logic [31:0] ac_ff;
  logic [31:0] cm_ff;
  logic en_ff;
  logic [3:0] ld_w;
  logic rx_w;
  logic edge_on;
  assign ld_w = ac_ff[7:4];
  assign rx_w = ac_ff[26];
  assign edge_on = cm_ff[11] & ~cm_ff[13] & ac_ff[26];

  ////////////////////////////////////////////////////////////////////////////
  // Shadow copy, so expectations never lean on the design's read path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ac_ff <= `MCS_RST_ALIGN_CTRL;
      cm_ff <= `MCS_RST_CHIP_MODE;
      en_ff <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `MCS_ADDR_ALIGN_CTRL) ac_ff <= bus_req.wdata;
      if (bus_req.addr == `MCS_ADDR_CHIP_MODE) cm_ff <= bus_req.wdata;
      if (bus_req.addr == `MCS_ADDR_FAULT) en_ff <= bus_req.wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_pulse_one_wide: assert property (
    init_pulse |=> !init_pulse) else $error("init pulse longer than one cycle");
  a_seq_load_value: assert property (
    init_pulse |=> seq_state == {1'b0, $past(ld_w)}) else $error("sequencer load wrong");
  a_seq_free_count: assert property (
    $past(rst_n) && !init_pulse |=> seq_state == $past(seq_state) + 5'h01)
    else $error("sequencer step wrong");
  a_rx_off_quiet: assert property (
    !rx_w && !$past(rx_w) |-> !init_pulse) else $error("pulse while receive off");
  a_edge_answer: assert property (
    $rose(align_rx_pin) && edge_on |-> ##[2:40] init_pulse) else $error("no pulse after edge");
  a_ctrl_readback: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == `MCS_ADDR_ALIGN_CTRL
    |-> bus_rdata == $past(ac_ff)) else $error("control readback wrong");
  a_irq_masked: assert property (
    !irq_n_oe_n |-> en_ff) else $error("masked fault drives request");
  a_flag_latched: assert property (
    !irq_n_oe_n && !bus_req.wr |=> !irq_n_oe_n) else $error("fault request dropped");
  a_fault_request: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == `MCS_ADDR_FAULT &&
    bus_rdata[`MCS_FS_FLAG] && en_ff |-> !irq_n_oe_n)
    else $error("enabled fault gives no request");
  a_od_drive_low: assert property (
    irq_n_out == 1'b0) else $error("request pin drives high");

  c_init: cover property (init_pulse);
  c_irq: cover property (!irq_n_oe_n);
  c_read: cover property (bus_req.rd ##1 bus_rdata != 32'h0);
endmodule

bind mcs_align_rx mcs_align_rx_sva u_sva (.sys_clk, .rst_n, .bus_req, .bus_rdata,
  .align_rx_pin, .init_pulse, .seq_state, .irq_n_out, .irq_n_oe_n);

// [sim/mcs_far_model.sv]
// Far side: clock distribution source of alignment pulses, code
// frames, a free-running data clock and the transmit strobe.
// Assumes tasks are called just after a sys_clk edge.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_far_model (
  // Sample clock
  input wire logic sys_clk,
  // Pins towards the device
  output logic align_pin,
  output logic strobe_pin,
  output logic dclk_pin
);
  logic [2:0] div_ff;
  initial begin
    align_pin = 1'b0;
    strobe_pin = 1'b1;
    div_ff = 3'h0;
  end
  // Data clock at an eighth of the sample rate, runs free
  always @(posedge sys_clk) div_ff <= div_ff + 3'h1;
  assign dclk_pin = div_ff[2];

  // Period 64 keeps rate at fdac/(16*4)
  task automatic pulse(input int len, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      align_pin <= 1'b1;
      repeat (len) @(posedge sys_clk);
      align_pin <= 1'b0;
      repeat (63 - len) @(posedge sys_clk);
    end
  endtask

  // Code then phase word, top chip first
  task automatic code(input logic [15:0] ph);
    logic [31:0] w;
    w = {`MCS_CODE_WORD, ph};
    for (int i = 31; i >= 0; i--) begin
      @(posedge sys_clk);
      align_pin <= w[i];
    end
    @(posedge sys_clk);
    align_pin <= 1'b0;
  endtask

  // Pulse against idle, moved on data clock fall
  task automatic strobe(input logic inv);
    @(posedge sys_clk);
    strobe_pin <= ~inv;
    repeat (32) @(posedge sys_clk);
    do @(posedge sys_clk); while (div_ff != 3'h0);
    strobe_pin <= inv;
    repeat (16) @(posedge sys_clk);
    strobe_pin <= ~inv;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the alignment receive block.
// Assumes the far-side model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module tb_top;
  import mcs_pkg::*;
  logic sys_clk;
  logic rst_n;
  mcs_bus_req_t req;
  logic [31:0] rdata, ftw, phase, v;
  logic [4:0] seq;
  logic [3:0] ld;
  logic pin, stb, dclk, pulse, od, oe_n;
  // Pull-up on the open-drain request line
  wire irq_w = oe_n ? 1'b1 : od;
  int num_errors;
  int n_compared;
  int seed;

  mcs_far_model u_far (.sys_clk, .align_pin(pin), .strobe_pin(stb), .dclk_pin(dclk));
  mcs_align_rx u_dut (.sys_clk, .rst_n, .bus_req(req), .bus_rdata(rdata),
    .align_rx_pin(pin), .transmit_strobe_pin(stb), .input_data_clock(dclk),
    .nco_ftw(ftw), .init_pulse(pulse), .seq_state(seq), .nco_phase(phase),
    .irq_n_in(irq_w), .irq_n_out(od), .irq_n_oe_n(oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk(rdata, exp);
  endtask

  // Bounded wait; a missing pulse counts and ends the run
  task automatic wait_pulse(input int lim);
    int k;
    k = 0;
    while (pulse !== 1'b1 && k < lim) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (pulse !== 1'b1) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hed34a5f5;
    req = '0;
    ftw = 32'h0;
    rst_n = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`MCS_ADDR_CHIP_MODE, `MCS_RST_CHIP_MODE);
    rd(`MCS_ADDR_ALIGN_CTRL, `MCS_RST_ALIGN_CTRL);
    rd(`MCS_ADDR_FAULT, 32'h0);
    wr(8'h05, $random(seed));
    rd(8'h05, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 32'hFBFFFFFF;
      wr(`MCS_ADDR_ALIGN_CTRL, v);
      rd(`MCS_ADDR_ALIGN_CTRL, v);
    end
    $display("test registers done");
    // Edge mode, margin check off, load value 15 then three random load values checked
    // edge mode bit pattern
    wr(`MCS_ADDR_CHIP_MODE, 32'h00000800);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      ld = (i == 0) ? 4'hF : v[3:0];
      wr(`MCS_ADDR_ALIGN_CTRL, {24'h040400, ld, 4'h0});
      fork u_far.pulse(16, 2); join_none
      wait_pulse(60);
      @(posedge sys_clk);
      #1;
      chk({27'h0, seq}, {28'h0, ld});
      wait_pulse(80);
      v = seq;
      chk({27'h0, v[4:0] + 5'h01}, {28'h0, ld});
      repeat (64) @(posedge sys_clk);
    end
    $display("test edge mode done");
    wr(`MCS_ADDR_ALIGN_CTRL, 32'h00040000);
    fork u_far.pulse(16, 1); join_none
    v = 0;
    repeat (70) begin
      @(posedge sys_clk);
      #1;
      if (pulse !== 1'b0) v++;
    end
    chk(v, 32'h0);
    $display("test receive off done");
    wr(`MCS_ADDR_CHIP_MODE, 32'h00003000);
    wr(`MCS_ADDR_ALIGN_CTRL, 32'h84040400);
    v = $random(seed);
    fork u_far.code(v[15:0]); join_none
    wait_pulse(60);
    repeat (30) @(posedge sys_clk);
    #1;
    chk(phase, {v[15:0], 16'h0});
    $display("test code mode done");
    wr(`MCS_ADDR_ALIGN_CTRL, 32'h04040000);
    for (int i = 0; i < 2; i++) begin
      wr(`MCS_ADDR_CHIP_MODE, {20'h0, 1'b1, 9'h0, i[0], 1'b0});
      fork u_far.strobe(i[0]); join_none
      repeat (2) @(posedge sys_clk);
      ftw <= $random(seed);
      repeat (20) @(posedge sys_clk);
      ftw <= 32'h0;
      @(posedge sys_clk);
      #1;
      chk({31'h0, phase === 32'h0}, 32'h0);
      repeat (60) @(posedge sys_clk);
      #1;
      chk(phase, 32'h0);
    end
    $display("test strobe done");
    // Manual margin procedure, delay tap 2, threshold 0
    wr(`MCS_ADDR_CHIP_MODE, 32'h00000800);
    wr(`MCS_ADDR_ALIGN_CTRL, 32'h04100000);
    wr(`MCS_ADDR_FAULT, 32'h1);
    wr(`MCS_ADDR_FAULT, 32'h41);
    rd(`MCS_ADDR_FAULT, 32'h1);
    u_far.pulse(16, 1);
    rd(`MCS_ADDR_FAULT, 32'h1);
    u_far.pulse(1, 1);
    rd(`MCS_ADDR_FAULT, 32'h51);
    repeat (20) @(posedge sys_clk);
    #1;
    chk({31'h0, irq_w}, 32'h0);
    wr(`MCS_ADDR_FAULT, 32'h41);
    rd(`MCS_ADDR_FAULT, 32'h11);
    chk({31'h0, irq_w}, 32'h1);
    wr(`MCS_ADDR_FAULT, 32'h0);
    u_far.pulse(1, 1);
    rd(`MCS_ADDR_FAULT, 32'h50);
    chk({31'h0, irq_w}, 32'h1);
    $display("test margin done");
    report_and_stop();
  end
endmodule
